// ===== common/smf_link_if.sv
// Purpose: carrier between the register core and the slave shifter
// Assumes: tx byte and mode bits stay still while a slave frame runs
// Notes: busy and done cross into the system domain inside the core
`timescale 1ns/1ps
`default_nettype none
interface smf_link_if;
    logic [7:0] tx_byte;   // byte to shift out as slave
    logic clock_polarity_sel;            // clock polarity select
    logic clock_phase_sel;            // clock phase select
    logic [7:0] rx_byte;   // last byte received as slave
    logic done_tgl;        // toggles once per received byte
    logic busy;            // a slave byte is under way
    logic miso_bit;        // bit to drive on the slave output
    modport core (
        output tx_byte, clock_polarity_sel, clock_phase_sel,
        input rx_byte, done_tgl, busy, miso_bit
    );
    modport shifter (
        input tx_byte, clock_polarity_sel, clock_phase_sel,
        output rx_byte, done_tgl, busy, miso_bit
    );
endinterface : smf_link_if
`default_nettype wire

// ===== common/smf_pkg.sv
// Purpose: shared constants for the serial master/slave engine
// Assumes: byte-wide transfers, msb first
// Notes: bit positions follow the control and status byte layout
package smf_pkg;
    // transfer size
    localparam int BYTE_W = 8;
    // serial clock edges per byte (two per bit)
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    // control byte field positions
    localparam int CR_IRQ_EN = 7;
    localparam int CR_PORT_EN = 6;
    localparam int CR_RATE2 = 5;
    localparam int CR_MASTER = 4;
    localparam int CR_CLOCK_POLARITY_SEL = 3;
    localparam int CR_CLOCK_PHASE_SEL = 2;
    localparam int CR_RATE1 = 1;
    localparam int CR_RATE0 = 0;
    // status byte field positions
    localparam int SR_DONE = 7;
    localparam int SR_WRITE_COLLISION_FLAG = 6;
    localparam int SR_MODE_FAULT_FLAG = 4;
    // values after reset
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] RATE_RST = 3'h0;
    // master state machine
    typedef enum logic [0:0] {
        SMF_IDLE,
        SMF_RUN
    } smf_mstate_t;
    // half serial period in system clocks for a rate code {rate2,rate1,rate0}
    function automatic logic [6:0] smf_rate_half(input logic [2:0] code);
        unique case (code)
            3'h4: smf_rate_half = 7'h02;  // divide by 4
            3'h0: smf_rate_half = 7'h04;  // divide by 8
            3'h1: smf_rate_half = 7'h08;  // divide by 16
            3'h6: smf_rate_half = 7'h10;  // divide by 32
            3'h2: smf_rate_half = 7'h20;  // divide by 64
            default: smf_rate_half = 7'h40;  // divide by 128, also unlisted codes
        endcase
    endfunction : smf_rate_half
endpackage : smf_pkg

// ===== hw/smf_core.sv
// Purpose: byte-wide serial master/slave engine with fault handling
// Assumes: software access strobes are one-cycle pulses on sys_clk_i
// Notes: master timing is derived from sys_clk_i, slave timing from the pin
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - serial clock idles at polarity level
// - phase one captures on second edge
// - phase zero captures on first edge
// - master launches bit one edge early
// - phase one allows back-to-back bytes
// - phase zero slave select low locks data register
// - busy write dropped, collision flag set
// - collision flag never interrupts
// - phase one slave outputs msb on edge
// - phase zero slave write after select collides
// - master write while shifting collides
// - select low as master sets fault
// - fault clears port enable and master
// - fault clears by status then control
// - fault blocks enable and master set
// - fault never sets as slave, persists
// - first byte kept until flag cleared
// - wait mode keeps running, wakes cpu
// - halt freezes every register but the synchronisers and the slave shifter
// - both events share gated interrupt
// - done flag set, cleared, blocks writes
// - eight pulses per byte, msb first
module smf_core (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // cpu state
    input wire logic halt_i,
    input wire logic cpu_irq_mask_i,
    // data register access
    input wire logic dr_wr_i,
    input wire logic [smf_pkg::BYTE_W-1:0] dr_wdata_i,
    input wire logic dr_rd_i,
    output logic [smf_pkg::BYTE_W-1:0] dr_rdata_o,
    // control and status access
    input wire logic cr_wr_i,
    input wire logic [7:0] cr_wdata_i,
    output logic [7:0] cr_rdata_o,
    input wire logic sr_acc_i,
    output logic [7:0] sr_rdata_o,
    // interrupt and wake requests
    output logic irq_o,
    output logic wake_o,
    // serial clock pin
    input wire logic spi_sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    // data pins
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    // select input
    input wire logic ss_n_i
);
    import smf_pkg::*;

    smf_link_if lnk ();

    // control fields
    logic irq_enable_q;
    logic port_enable_q;
    logic master_select_q;
    logic clock_polarity_sel_q;
    logic clock_phase_sel_q;
    logic [2:0] rate_q;            // {rate2, rate1, rate0}
    // status flags and their clearing arms
    logic transfer_done_flag_q;
    logic done_arm_q;              // status seen while done was set
    logic write_collision_flag_q;
    logic write_collision_flag_arm_q;
    logic mode_fault_flag_q;
    logic mode_fault_flag_arm_q;
    // data path
    logic [7:0] shift_data_reg_q;  // slave transmit byte
    logic [7:0] rx_buf_q;          // what a data read returns
    // master engine
    smf_mstate_t mst_q;
    logic [6:0] half_cnt_q;        // system clocks left in this half period
    logic [4:0] edge_cnt_q;        // serial edges already made
    logic sck_lvl_q;               // clock level with polarity taken out
    logic [7:0] tx_sh_q;           // master transmit shifter
    logic [7:0] rx_sh_q;           // master receive shifter
    // synchronisers from pins and from the link domain
    logic [1:0] ss_sync_q;
    logic [1:0] miso_sync_q;
    logic [1:0] busy_sync_q;
    logic [2:0] done_sync_q;       // third stage only feeds the edge detector
    // decoded events
    logic ss_n_s;
    logic miso_s;
    logic slv_busy_s;
    logic slv_done;
    logic m_edge;                  // a serial edge is made this cycle
    logic [4:0] edge_num;          // number of the edge being made
    logic m_sample;
    logic m_done;
    logic [7:0] m_final;
    logic is_master;
    logic collide;
    logic dr_blocked;
    logic dr_take;
    logic byte_end;
    logic fault;
    logic en_ok;                   // enable and master may be set

    // slave shifter on the link clock
    smf_slave_shifter #(
        .BITS(BYTE_W)
    ) u_slave (
        .rst_b_i(rst_b_i),
        .sck_i(spi_sck_i),
        .ss_n_i(ss_n_i),
        .mosi_i(mosi_i),
        .lnk(lnk)
    );

    // mode bits and transmit byte are still while the far end clocks them
    assign lnk.tx_byte = shift_data_reg_q;
    assign lnk.clock_polarity_sel = clock_polarity_sel_q;
    assign lnk.clock_phase_sel = clock_phase_sel_q;

    // two-stage synchronisers, three for done; only the second stage is read, except that the done edge detector also reads the third
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ss_sync_q <= 2'h3;
            miso_sync_q <= 2'h0;
            busy_sync_q <= 2'h0;
            done_sync_q <= 3'h0;
        end else begin
            ss_sync_q <= {ss_sync_q[0], ss_n_i};
            miso_sync_q <= {miso_sync_q[0], miso_i};
            busy_sync_q <= {busy_sync_q[0], lnk.busy};
            done_sync_q <= {done_sync_q[1:0], lnk.done_tgl};
        end
    end

    assign ss_n_s = ss_sync_q[1];
    assign miso_s = miso_sync_q[1];
    assign slv_busy_s = busy_sync_q[1];
    // toggle edge marks one received slave byte
    assign slv_done = done_sync_q[2] ^ done_sync_q[1];

    assign is_master = port_enable_q & master_select_q;

    // master edge bookkeeping
    assign m_edge = (mst_q == SMF_RUN) && (half_cnt_q == 7'h00);
    assign edge_num = 5'(edge_cnt_q + 5'h01);
    assign m_sample = clock_phase_sel_q ? ~edge_num[0] : edge_num[0];
    assign m_done = m_edge && (edge_num == EDGES_PER_BYTE);
    // phase one takes its last bit on the final edge itself
    assign m_final = clock_phase_sel_q ? {rx_sh_q[6:0], miso_s} : rx_sh_q;
    assign byte_end = m_done | slv_done;

    // slave select low locks the byte
    // phase zero slave: select low collides
    // phase one: idle select low is fine
    assign collide = (mst_q == SMF_RUN) |
                     (port_enable_q & ~master_select_q &
                      ((~clock_phase_sel_q & ~ss_n_s) | slv_busy_s));
    // done set blocks writes until status seen
    assign dr_blocked = transfer_done_flag_q & ~done_arm_q;
    assign dr_take = dr_wr_i & ~halt_i & ~collide & ~dr_blocked;

    // relies on select held high as master
    assign fault = is_master & ~ss_n_s & ~halt_i;
    // while a fault is pending only the clearing write may set them
    assign en_ok = ~mode_fault_flag_q | mode_fault_flag_arm_q;

    // control register; a fault overrides the enable and master bits of a write in the same cycle
    // halt freezes the registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_enable_q <= 1'b0;
            port_enable_q <= 1'b0;
            master_select_q <= 1'b0;
            clock_polarity_sel_q <= 1'b0;
            clock_phase_sel_q <= 1'b0;
            rate_q <= RATE_RST;
        end else if (!halt_i) begin
            if (cr_wr_i) begin
                irq_enable_q <= cr_wdata_i[CR_IRQ_EN];
                clock_polarity_sel_q <= cr_wdata_i[CR_CLOCK_POLARITY_SEL];
                clock_phase_sel_q <= cr_wdata_i[CR_CLOCK_PHASE_SEL];
                rate_q <= {cr_wdata_i[CR_RATE2], cr_wdata_i[CR_RATE1],
                           cr_wdata_i[CR_RATE0]};
                port_enable_q <= cr_wdata_i[CR_PORT_EN] & en_ok;
                master_select_q <= cr_wdata_i[CR_MASTER] & en_ok;
            end
            if (fault) begin
                port_enable_q <= 1'b0;
                master_select_q <= 1'b0;
            end
        end
    end

    // mode fault flag; a new fault wins over the clearing write
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_fault_flag_q <= 1'b0;
            mode_fault_flag_arm_q <= 1'b0;
        end else if (!halt_i) begin
            // status access arms, control write clears
            if (fault) begin
                mode_fault_flag_q <= 1'b1;
                mode_fault_flag_arm_q <= 1'b0;
            end else if (mode_fault_flag_arm_q && cr_wr_i) begin
                mode_fault_flag_q <= 1'b0;
                mode_fault_flag_arm_q <= 1'b0;
            end else if (sr_acc_i && mode_fault_flag_q) begin
                mode_fault_flag_arm_q <= 1'b1;
            end
        end
    end

    // transfer done flag; a byte ending in the clearing cycle keeps it set
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            transfer_done_flag_q <= 1'b0;
            done_arm_q <= 1'b0;
        end else if (!halt_i) begin
            // byte end sets, status then read clears
            if (byte_end) begin
                transfer_done_flag_q <= 1'b1;
                done_arm_q <= 1'b0;
            end else if (done_arm_q && dr_rd_i) begin
                transfer_done_flag_q <= 1'b0;
                done_arm_q <= 1'b0;
            end else if (sr_acc_i && transfer_done_flag_q) begin
                done_arm_q <= 1'b1;
            end
        end
    end

    // write collision flag; a new collision wins over the clearing access
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            write_collision_flag_q <= 1'b0;
            write_collision_flag_arm_q <= 1'b0;
        end else if (!halt_i) begin
            if (dr_wr_i && collide) begin
                write_collision_flag_q <= 1'b1;
                write_collision_flag_arm_q <= 1'b0;
            // status read arms, data access clears
            end else if (write_collision_flag_arm_q && (dr_rd_i || dr_wr_i)) begin
                write_collision_flag_q <= 1'b0;
                write_collision_flag_arm_q <= 1'b0;
            end else if (sr_acc_i && write_collision_flag_q) begin
                write_collision_flag_arm_q <= 1'b1;
            end
        end
    end

    // data register and receive buffer
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_data_reg_q <= BYTE_RST;
            rx_buf_q <= BYTE_RST;
        end else if (!halt_i) begin
            // accepted only when no transfer runs
            if (dr_take) begin
                shift_data_reg_q <= dr_wdata_i;
            end
            // later bytes lost while done is set
            if (byte_end && !transfer_done_flag_q) begin
                rx_buf_q <= m_done ? m_final : lnk.rx_byte;
            end
        end
    end

    // master sequencer: half-period divider, edge count and shifters
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mst_q <= SMF_IDLE;
            half_cnt_q <= 7'h00;
            edge_cnt_q <= 5'h00;
            sck_lvl_q <= 1'b0;
            tx_sh_q <= BYTE_RST;
            rx_sh_q <= BYTE_RST;
        end else if (!halt_i) begin
            unique case (mst_q)
                SMF_IDLE: begin
                    sck_lvl_q <= 1'b0;
                    // a write as master starts the byte
                    if (dr_take && is_master) begin
                        mst_q <= SMF_RUN;
                        half_cnt_q <= 7'(smf_rate_half(rate_q) - 7'h01);
                        edge_cnt_q <= 5'h00;
                        tx_sh_q <= dr_wdata_i;
                    end
                end
                SMF_RUN: begin
                    if (!is_master) begin
                        // fault or software dropped master: abandon quietly
                        mst_q <= SMF_IDLE;
                    end else if (m_edge) begin
                        half_cnt_q <= 7'(smf_rate_half(rate_q) - 7'h01);
                        edge_cnt_q <= edge_num;
                        sck_lvl_q <= ~sck_lvl_q;
                        if (m_sample) begin
                            rx_sh_q <= {rx_sh_q[6:0], miso_s};
                        // next bit launched one edge early
                        end else if (edge_num != 5'h01) begin
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                        end
                        if (m_done) begin
                            mst_q <= SMF_IDLE;
                        end
                    end else begin
                        half_cnt_q <= 7'(half_cnt_q - 7'h01);
                    end
                end
            endcase
        end
    end

    // register read views
    assign dr_rdata_o = rx_buf_q;
    assign cr_rdata_o = {irq_enable_q, port_enable_q, rate_q[2], master_select_q,
                         clock_polarity_sel_q, clock_phase_sel_q, rate_q[1:0]};
    assign sr_rdata_o = {transfer_done_flag_q, write_collision_flag_q, 1'b0,
                         mode_fault_flag_q, 4'h0};

    // done and fault share one gated line
    assign irq_o = irq_enable_q & (transfer_done_flag_q | mode_fault_flag_q) &
                   ~cpu_irq_mask_i;
    // events wake from wait, never halt
    // halt is left only by others
    assign wake_o = irq_enable_q & (transfer_done_flag_q | mode_fault_flag_q) & ~halt_i;

    // clock idles at the polarity level
    assign sck_o = clock_polarity_sel_q ^ sck_lvl_q;
    assign sck_oe_n_o = ~is_master;
    assign mosi_o = tx_sh_q[7];
    assign mosi_oe_n_o = ~is_master;
    assign miso_o = lnk.miso_bit;
    assign miso_oe_n_o = ~(port_enable_q & ~master_select_q & ~ss_n_s);
endmodule : smf_core
`default_nettype wire

// ===== hw/smf_slave_shifter.sv
// Purpose: slave-side shifter running on the incoming serial clock
// Assumes: serial clock stands still while select is high
// Notes: select high clears the bit counters, the byte toggle survives it
`timescale 1ns/1ps
`default_nettype none
module smf_slave_shifter #(
    parameter int BITS = 8
) (
    // reset and link pins
    input wire logic rst_b_i,
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    // core side
    smf_link_if.shifter lnk
);
    import smf_pkg::*;

    // the counters below are three bits wide
    if (BITS != BYTE_W) begin : g_bits_chk
        $error("smf_slave_shifter: only 8-bit bytes are supported");
    end

    logic sclk;            // rises on every capture edge
    logic arst_n;          // frame reset: chip reset or select released
    logic [2:0] smp_cnt_q; // capture edges seen in this byte
    logic [2:0] sh_cnt_q;  // launch edges seen in this byte
    logic [6:0] rx_sh_q;   // bits captured so far
    logic [2:0] tx_idx;    // bit now on the output

    // phase one: capture on second edge
    // phase zero: capture on first edge
    assign sclk = sck_i ^ lnk.clock_polarity_sel ^ lnk.clock_phase_sel;
    assign arst_n = rst_b_i & ~ss_n_i;

    // capture side, cleared between frames by select
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            smp_cnt_q <= 3'h0;
            rx_sh_q <= 7'h00;
        end else begin
            smp_cnt_q <= smp_cnt_q + 3'h1;
            rx_sh_q <= {rx_sh_q[5:0], mosi_i};
        end
    end

    // byte hand-off, only chip reset clears it so no false event appears
    always_ff @(posedge sclk or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lnk.done_tgl <= 1'b0;
            lnk.rx_byte <= BYTE_RST;
        end else if (smp_cnt_q == 3'h7) begin
            lnk.done_tgl <= ~lnk.done_tgl;
            lnk.rx_byte <= {rx_sh_q, mosi_i};
        end
    end

    // launch side counts the edges between captures
    always_ff @(negedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            sh_cnt_q <= 3'h0;
        end else begin
            sh_cnt_q <= sh_cnt_q + 3'h1;
        end
    end

    // phase one: msb appears on first edge
    assign tx_idx = lnk.clock_phase_sel ? 3'(3'h0 - sh_cnt_q) : 3'(3'h7 - sh_cnt_q);
    assign lnk.miso_bit = lnk.clock_phase_sel & (sh_cnt_q == smp_cnt_q) & (smp_cnt_q == 3'h0)
                          ? 1'b0 : lnk.tx_byte[tx_idx];

    // a byte is under way once any edge has been seen and until both counters meet at zero;
    // the core passes this level through two flip-flops
    assign lnk.busy = (smp_cnt_q != 3'h0) | (sh_cnt_q != smp_cnt_q);
endmodule : smf_slave_shifter
`default_nettype wire

// ===== sim/smf_core_assertions.sv
// Purpose: port-level checks for the serial engine
// Assumes: one system clock domain
// Notes: bound to every smf_core instance
`timescale 1ns/1ps
`default_nettype none
module smf_core_assertions
    import smf_pkg::*;
(
    // clock, reset, cpu state, strobes, select
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic halt_i,
    input wire logic cpu_irq_mask_i,
    input wire logic dr_wr_i,
    input wire logic dr_rd_i,
    input wire logic cr_wr_i,
    input wire logic ss_n_i,
    // observed outputs
    input wire logic [7:0] cr_rdata_o,
    input wire logic [7:0] sr_rdata_o,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic sck_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // named control and status bits
    logic done, write_collision_flag, mode_fault_flag, en, mst, ie;
    assign {done, write_collision_flag, mode_fault_flag} = {sr_rdata_o[SR_DONE], sr_rdata_o[SR_WRITE_COLLISION_FLAG], sr_rdata_o[SR_MODE_FAULT_FLAG]};
    assign {ie, en, mst} = {cr_rdata_o[CR_IRQ_EN], cr_rdata_o[CR_PORT_EN], cr_rdata_o[CR_MASTER]};
    chk_irq_gate: assert property (
        irq_o == (ie && (done || mode_fault_flag) && !cpu_irq_mask_i)) else $error("irq gating wrong");
    chk_wake_level: assert property (
        wake_o == (ie && (done || mode_fault_flag) && !halt_i)) else $error("wake level wrong");
    chk_write_collision_flag_quiet: assert property (
        $rose(write_collision_flag) && !done && !mode_fault_flag |-> !irq_o) else $error("collision raised irq");
    chk_fault_trip: assert property (
        $fell(ss_n_i) && en && mst && !halt_i ##1 (!ss_n_i && !halt_i)[*2]
        |=> mode_fault_flag && !en && !mst) else $error("mode fault not taken");
    chk_fault_master: assert property (
        $rose(mode_fault_flag) |-> $past(mst)) else $error("fault set as slave");
    chk_mode_fault_flag_clear: assert property (
        $fell(mode_fault_flag) |-> $past(cr_wr_i)) else $error("fault flag cleared early");
    chk_done_clear: assert property (
        $fell(done) |-> $past(dr_rd_i)) else $error("done cleared early");
    chk_write_collision_flag_clear: assert property (
        $fell(write_collision_flag) |-> $past(dr_rd_i || dr_wr_i)) else $error("collision cleared early");
    chk_halt_freeze: assert property (
        halt_i |=> $stable(cr_rdata_o) && $stable(sr_rdata_o)) else $error("halt not frozen");
    chk_slave_lock: assert property (
        (!ss_n_i)[*3] ##0 (dr_wr_i && en && !mst && !cr_rdata_o[CR_CLOCK_PHASE_SEL] && !halt_i && !done)
        |=> write_collision_flag) else $error("locked write not flagged");
    chk_sck_idle: assert property (
        en && mst && done && $past(done) |-> sck_o == cr_rdata_o[CR_CLOCK_POLARITY_SEL])
        else $error("clock not idle");
endmodule : smf_core_assertions
bind smf_core smf_core_assertions u_chk (.sys_clk_i, .rst_b_i, .halt_i, .cpu_irq_mask_i,
    .dr_wr_i, .dr_rd_i, .cr_wr_i, .ss_n_i, .cr_rdata_o, .sr_rdata_o, .irq_o, .wake_o, .sck_o);
`default_nettype wire

// ===== sim/smf_far_master.sv
// Purpose: far-end serial master for the slave link
// Assumes: called only between frames
// Notes: link clock stands still outside frames
`timescale 1ns/1ps
`default_nettype none
module smf_far_master (
    // link pins
    output logic sck_o,
    output logic ss_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // idle: select high
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b1;
    end
    // one byte at a 32 ns period; keep holds select low after it
    task automatic xfer(input logic clock_polarity_sel, input logic clock_phase_sel, input logic [7:0] tx,
                        input logic keep, output logic [7:0] rx);
        sck_o = clock_polarity_sel;
        #40 ss_n_o = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) begin
            // phase zero: data ahead, capture on first edge
            if (!clock_phase_sel) mosi_o = tx[i];
            #16 sck_o = ~sck_o;
            if (clock_phase_sel) mosi_o = tx[i];
            else rx[i] = miso_i;
            #16 sck_o = ~sck_o;
            if (clock_phase_sel) rx[i] = miso_i;
        end
        // released data shows a changed level, not the last bit
        #16 mosi_o = ~mosi_o;
        if (!keep) ss_n_o = 1'b1;
    endtask : xfer
endmodule : smf_far_master
`default_nettype wire

// ===== sim/test_smf_core.sv
// Purpose: directed bench for the serial engine
// Assumes: master output looped to its own input
// Notes: slowest rate keeps the synced input safe
`timescale 1ns/1ps
`default_nettype none
module test_smf_core;
    import smf_pkg::*;
    logic clk, rst_b, halt, mask, dr_wr, dr_rd, cr_wr, sr_acc, ss_force_n;
    logic [7:0] wdata, drd, crd, srd, rx, tx;
    logic irq, wake, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, psck, pss_n, pmosi;
    int fails, compares, edges;
    always #2.5 clk = ~clk;
    // master clock toggles
    always @(sck) edges = edges + 1;
    // select held high unless a fault or collision is staged or the far master runs a frame
    smf_core DUT (.sys_clk_i(clk), .rst_b_i(rst_b), .halt_i(halt), .cpu_irq_mask_i(mask),
        .dr_wr_i(dr_wr), .dr_wdata_i(wdata), .dr_rd_i(dr_rd), .dr_rdata_o(drd),
        .cr_wr_i(cr_wr), .cr_wdata_i(wdata), .cr_rdata_o(crd), .sr_acc_i(sr_acc),
        .sr_rdata_o(srd), .irq_o(irq), .wake_o(wake), .spi_sck_i(psck), .sck_o(sck),
        .sck_oe_n_o(sck_oe_n), .mosi_i(pmosi), .mosi_o(mosi), .mosi_oe_n_o(mosi_oe_n),
        .miso_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n), .ss_n_i(pss_n & ss_force_n));
    smf_far_master P (.sck_o(psck), .ss_n_o(pss_n), .mosi_o(pmosi), .miso_i(miso));
    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // strobe kind: 0 control, 1 data write, 2 data read, 3 status access
    task automatic acc(input int k, input logic [7:0] v);
        wdata = v;
        {sr_acc, dr_rd, dr_wr, cr_wr} = 4'h1 << k;
        tick(1);
        {sr_acc, dr_rd, dr_wr, cr_wr} = 4'h0;
        tick(1);
    endtask : acc
    // bounded poll on the done flag
    task automatic wait_done();
        int n;
        n = 0;
        while (srd[SR_DONE] !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n == 3000) begin
            fails++;
            $display("[ERR] %0t done timeout", $time);
            wrap_up();
        end
    endtask : wait_done
    initial begin
        {clk, rst_b, halt, mask, dr_wr, dr_rd, cr_wr, sr_acc} = 8'h00;
        {ss_force_n, wdata, edges, fails, compares} = '0;
        ss_force_n = 1'b1;
        tick(3);
        rst_b = 1'b1;
        tick(3);
        // master bytes in all four modes, mask high in the last two
        for (int m = 0; m < 4; m++) begin
            mask = m[1];
            acc(0, {4'hD, m[1:0], 2'h3});
            edges = 0;
            tx = {m[1:0], 6'h25};
            acc(1, tx);
            if (m == 0) begin
                tick(20);
                acc(1, 8'hFF);
                chk(srd, 8'h40);
            end
            wait_done();
            tick(1);
            chk(drd, tx);
            chk(8'(edges), 8'h10);
            chk({7'h0, sck}, {7'h0, m[1]});
            chk({6'h0, irq, wake}, {6'h0, ~m[1], 1'b1});
            acc(3, 8'h00);
            acc(2, 8'h00);
            chk(srd, 8'h00);
        end
        // select pulled low under an enabled master
        mask = 1'b0;
        acc(0, 8'hD3);
        ss_force_n = 1'b0;
        tick(5);
        chk(srd, 8'h10);
        chk(crd, 8'h83);
        chk({5'h0, irq, sck_oe_n, mosi_oe_n}, 8'h07);
        acc(0, 8'hD3);
        chk(crd, 8'h83);
        ss_force_n = 1'b1;
        acc(3, 8'h00);
        acc(0, 8'hD3);
        chk(srd, 8'h00);
        chk(crd, 8'hD3);
        // writes under halt do nothing
        halt = 1'b1;
        acc(1, 8'h77);
        tick(200);
        chk(srd, 8'h00);
        halt = 1'b0;
        // slave: two bytes per mode, second before the flag is cleared
        for (int m = 0; m < 4; m++) begin
            acc(0, {4'hC, m[1:0], 2'h0});
            tx = {m[1:0], 6'h1B};
            acc(1, tx);
            P.xfer(m[1], m[0], 8'h96, m[0], rx);
            chk(rx, tx);
            P.xfer(m[1], m[0], 8'h69, 1'b0, rx);
            tick(8);
            wait_done();
            chk(drd, 8'h96);
            chk(srd, 8'h80);
            acc(3, 8'h00);
            acc(2, 8'h00);
        end
        // phase zero slave: write after select low collides
        acc(0, 8'hC0);
        ss_force_n = 1'b0;
        tick(4);
        acc(1, 8'h11);
        chk(srd, 8'h40);
        chk({6'h0, irq, miso_oe_n}, 8'h00);
        ss_force_n = 1'b1;
        acc(3, 8'h00);
        acc(2, 8'h00);
        chk(srd, 8'h00);
        wrap_up();
    end
endmodule : test_smf_core
`default_nettype wire
